// File: logic/gsitp_pkg.sv
// Shared constants and types for the sensor serial target port and its master.
`default_nettype none
package gsitp_pkg;

  // ****************************************************************
  // Addressing and register map
  // ****************************************************************
  localparam logic [6:0] GSITP_TARGET_ADDR = 7'h55;
  localparam logic [7:0] GSITP_REG_STATUS  = 8'h00;
  localparam logic [7:0] GSITP_REG_SHUTDN  = 8'h01;
  localparam logic [7:0] GSITP_REG_CONFIG  = 8'h11;
  localparam logic [7:0] GSITP_SHUTDN_RST  = 8'h00;
  localparam logic [7:0] GSITP_CONFIG_RST  = 8'h00;
  localparam int         GSITP_SSD_BIT     = 0;
  localparam int         GSITP_MODE_BIT    = 0;
  localparam logic [3:0] GSITP_BIT_LAST    = 4'h7;
  localparam logic [3:0] GSITP_BIT_ACK     = 4'h8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int GSITP_CLK_MHZ       = 200;
  localparam int GSITP_IRQ_HOLD_MS   = 10;
  localparam int GSITP_IRQ_HOLD_CYC  = GSITP_IRQ_HOLD_MS * 1000 * 1000 * GSITP_CLK_MHZ / 1000;
  localparam int GSITP_SCL_MAX_KHZ   = 400;
  localparam int GSITP_SCL_HALF_CYC  =
    (GSITP_CLK_MHZ * 1000 + 2 * GSITP_SCL_MAX_KHZ - 1) / (2 * GSITP_SCL_MAX_KHZ);

  typedef enum {GSITP_T_IDLE, GSITP_T_RX, GSITP_T_ACK, GSITP_T_TX, GSITP_T_TXACK,
                GSITP_T_IGNORE} gsitp_tstate_t;

  typedef enum {GSITP_M_IDLE, GSITP_M_START, GSITP_M_BITLO, GSITP_M_BITHI,
                GSITP_M_STOPLO, GSITP_M_STOPHI, GSITP_M_DONE} gsitp_mstate_t;

endpackage : gsitp_pkg
`default_nettype wire

// File: logic/gsitp_bus_if.sv
// Two-wire bus between the sensor target port and the host master.
`timescale 1ns/10ps
`default_nettype none
interface gsitp_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_in;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_t_o;
  logic sda_t_oe;
  logic scl_in;
  logic irq_request_n;
  logic hw_shutdown_n;

  // Open-drain wired level, pulled up when nobody drives low.
  assign sda_in = !((sda_m_oe && !sda_m_o) || (sda_t_oe && !sda_t_o));
  assign scl_in = !(scl_oe && !scl_o);

  modport target (input scl_in, input sda_in, output sda_t_o, output sda_t_oe,
                  output irq_request_n, input hw_shutdown_n);
  modport master (output scl_o, output scl_oe, input sda_in, output sda_m_o,
                  output sda_m_oe, input irq_request_n, output hw_shutdown_n);
endinterface : gsitp_bus_if
`default_nettype wire

// File: logic/gsitp_target.sv
// Serial target port of the motion sensor with its registers and interrupt.
`timescale 1ns/10ps
`default_nettype none
module gsitp_target
  import gsitp_pkg::*;
#(
  parameter int IRQ_HOLD_CYC = GSITP_IRQ_HOLD_CYC
) (
  input  wire logic  clk_sys,
  input  wire logic  resetn,
  gsitp_bus_if.target bus,
  input  wire logic  motion_event,
  input  wire logic [3:0] motion_flags,
  output logic       shutdown,
  output logic       prox_mode,
  output logic [2:0] emit_current,
  output logic [7:0] wr_data,
  output logic [7:0] wr_addr,
  output logic       wr_strobe
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] scl_sync_q, sda_sync_q, sdn_sync_q;
  logic [1:0] scl_sync_d, sda_sync_d, sdn_sync_d;
  logic       scl_prev_q, sda_prev_q, scl_prev_d, sda_prev_d;

  always_comb begin
    scl_sync_d = {scl_sync_q[0], bus.scl_in};
    sda_sync_d = {sda_sync_q[0], bus.sda_in};
    sdn_sync_d = {sdn_sync_q[0], bus.hw_shutdown_n};
    scl_prev_d = scl_sync_q[1];
    sda_prev_d = sda_sync_q[1];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      sdn_sync_q <= 2'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= scl_sync_d;
      sda_sync_q <= sda_sync_d;
      sdn_sync_q <= sdn_sync_d;
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl      = scl_sync_q[1];
  assign sda      = sda_sync_q[1];
  assign scl_rise = scl && !scl_prev_q;
  assign scl_fall = !scl && scl_prev_q;
  assign start_ev = scl && scl_prev_q && sda_prev_q && !sda;
  assign stop_ev  = scl && scl_prev_q && !sda_prev_q && sda;

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  gsitp_tstate_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [1:0] byte_q, byte_d;
  logic       rd_q, rd_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] sdn_reg_q, sdn_reg_d, cfg_q, cfg_d, stat_q, stat_d;
  logic       sda_low_q, sda_low_d;
  logic [7:0] wr_data_q, wr_data_d, wr_addr_q, wr_addr_d;
  logic       wr_stb_q, wr_stb_d, stat_rd;
  logic [23:0] irq_cnt_q, irq_cnt_d;
  logic       irq_q, irq_d;
  logic       sdn_out;

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] s,
                                          input logic [7:0] d, input logic [7:0] c);
    case (a)
      GSITP_REG_STATUS: reg_read = s;
      GSITP_REG_SHUTDN: reg_read = d;
      GSITP_REG_CONFIG: reg_read = c;
      default:          reg_read = 8'h00;
    endcase
  endfunction

  always_comb begin
    st_d      = st_q;
    bit_d     = bit_q;
    sh_d      = sh_q;
    byte_d    = byte_q;
    rd_d      = rd_q;
    ptr_d     = ptr_q;
    sdn_reg_d = sdn_reg_q;
    cfg_d     = cfg_q;
    sda_low_d = sda_low_q;
    wr_data_d = wr_data_q;
    wr_addr_d = wr_addr_q;
    wr_stb_d  = 1'b0;
    stat_rd   = 1'b0;
    stat_d = motion_event ? {4'h0, motion_flags} : stat_q;
    if (start_ev) begin
      st_d = GSITP_T_RX; bit_d = 4'h0; byte_d = 2'h0; sda_low_d = 1'b0;
    end else if (stop_ev) begin
      st_d = GSITP_T_IDLE; sda_low_d = 1'b0;
    end else begin
      case (st_q)
        GSITP_T_IDLE, GSITP_T_IGNORE: sda_low_d = 1'b0;
        GSITP_T_RX: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q == GSITP_BIT_ACK) begin
            bit_d = 4'h0;
            st_d  = GSITP_T_ACK;
            if (byte_q == 2'h0) begin
              if (sh_q[7:1] == GSITP_TARGET_ADDR) begin
                sda_low_d = 1'b1;
                rd_d = sh_q[0];
                if (sh_q[0]) begin
                  sh_d = reg_read(ptr_q, stat_q, sdn_reg_q, cfg_q);
                  stat_rd = (ptr_q == GSITP_REG_STATUS);
                end
              end else begin
                st_d = GSITP_T_IGNORE;
              end
            end else if (byte_q == 2'h1) begin
              ptr_d = sh_q; sda_low_d = 1'b1;
            end else begin
              sda_low_d = 1'b1;
              wr_data_d = sh_q; wr_addr_d = ptr_q; wr_stb_d = 1'b1;
              if (ptr_q == GSITP_REG_SHUTDN) sdn_reg_d = sh_q;
              if (ptr_q == GSITP_REG_CONFIG) cfg_d = sh_q;
            end
          end
        end
        GSITP_T_ACK: if (scl_fall) begin
          if (rd_q) begin
            st_d = GSITP_T_TX; sda_low_d = !sh_q[7];
          end else begin
            st_d = GSITP_T_RX; sda_low_d = 1'b0;
            byte_d = (byte_q == 2'h2) ? 2'h2 : byte_q + 2'h1;
          end
        end
        GSITP_T_TX: begin
          if (scl_rise) bit_d = bit_q + 4'h1;
          if (scl_fall) begin
            sh_d = {sh_q[6:0], 1'b1};
            if (bit_q == GSITP_BIT_LAST + 4'h1) begin
              st_d = GSITP_T_TXACK; sda_low_d = 1'b0; bit_d = 4'h0;
            end else sda_low_d = !sh_q[6];
          end
        end
        GSITP_T_TXACK: begin
          if (scl_rise && sda) st_d = GSITP_T_IGNORE;
          if (scl_fall && st_d == GSITP_T_TXACK) begin
            sh_d = reg_read(ptr_q, stat_q, sdn_reg_q, cfg_q);
            st_d = GSITP_T_TX; sda_low_d = !sh_d[7];
          end
        end
        default: st_d = GSITP_T_IDLE;
      endcase
    end
    // Interrupt: a new event wins over a clear in the same cycle.
    irq_d = irq_q; irq_cnt_d = irq_cnt_q;
    if (motion_event && !sdn_out) begin
      irq_d = 1'b1; irq_cnt_d = '0;
    end else if (irq_q) begin
      if (stat_rd || irq_cnt_q >= 24'(IRQ_HOLD_CYC - 1)) irq_d = 1'b0;
      irq_cnt_d = irq_cnt_q + 24'h1;
    end
  end

  assign sdn_out = !sdn_sync_q[1] || !sdn_reg_q[GSITP_SSD_BIT];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q      <= GSITP_T_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      byte_q    <= 2'h0;
      rd_q      <= 1'b0;
      ptr_q     <= 8'h00;
      sdn_reg_q <= GSITP_SHUTDN_RST;
      cfg_q     <= GSITP_CONFIG_RST;
      stat_q    <= 8'h00;
      sda_low_q <= 1'b0;
      wr_data_q <= 8'h00;
      wr_addr_q <= 8'h00;
      wr_stb_q  <= 1'b0;
      irq_cnt_q <= 24'h0;
      irq_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      bit_q     <= bit_d;
      sh_q      <= sh_d;
      byte_q    <= byte_d;
      rd_q      <= rd_d;
      ptr_q     <= ptr_d;
      sdn_reg_q <= sdn_reg_d;
      cfg_q     <= cfg_d;
      stat_q    <= stat_d;
      sda_low_q <= sda_low_d;
      wr_data_q <= wr_data_d;
      wr_addr_q <= wr_addr_d;
      wr_stb_q  <= wr_stb_d;
      irq_cnt_q <= irq_cnt_d;
      irq_q     <= irq_d;
    end
  end

  // Open drain: only ever drive low, otherwise release the line.
  assign bus.sda_t_o       = 1'b0;
  assign bus.sda_t_oe      = sda_low_q;
  assign bus.irq_request_n = !irq_q;
  assign shutdown          = sdn_out;
  assign prox_mode         = cfg_q[GSITP_MODE_BIT];
  assign emit_current      = cfg_q[GSITP_MODE_BIT + 1 +: 3];
  assign wr_data           = wr_data_q;
  assign wr_addr           = wr_addr_q;
  assign wr_strobe         = wr_stb_q;

endmodule : gsitp_target
`default_nettype wire

// File: logic/gsitp_master.sv
// Host-side bus master that performs register writes and reads on the sensor.
`timescale 1ns/10ps
`default_nettype none
module gsitp_master
  import gsitp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  gsitp_bus_if.master     bus,
  input  wire logic       req_valid,
  input  wire logic       req_read,
  input  wire logic [7:0] req_reg,
  input  wire logic [7:0] req_data,
  input  wire logic       shutdown_req,
  output logic            req_ready,
  output logic            done,
  output logic            nack,
  output logic [7:0]      rd_data,
  output logic            irq_pending
);

  logic [1:0] sda_sync_q, irq_sync_q;
  gsitp_mstate_t st_q, st_d;
  logic [15:0] tmr_q, tmr_d;
  logic [3:0]  bit_q, bit_d;
  logic [2:0]  ph_q, ph_d;
  logic [7:0]  sh_q, sh_d, rdat_q, rdat_d, reg_q, reg_d, dat_q, dat_d;
  logic        rd_q, rd_d, scl_q, scl_d, sdo_q, sdo_d, nack_q, nack_d, done_q, done_d;

  // Phases: 0 addr-write, 1 register, 2 data, 3 addr-read, 4 read byte.
  function automatic logic [7:0] phase_byte(input logic [2:0] p, input logic [7:0] r,
                                            input logic [7:0] d);
    case (p)
      3'h0:    phase_byte = {GSITP_TARGET_ADDR, 1'b0};
      3'h1:    phase_byte = r;
      3'h2:    phase_byte = d;
      3'h3:    phase_byte = {GSITP_TARGET_ADDR, 1'b1};
      default: phase_byte = 8'hff;
    endcase
  endfunction

  logic tick;
  assign tick = (tmr_q == 16'(GSITP_SCL_HALF_CYC - 1));

  always_comb begin
    st_d = st_q; bit_d = bit_q; ph_d = ph_q; sh_d = sh_q; rdat_d = rdat_q;
    reg_d = reg_q; dat_d = dat_q; rd_d = rd_q; scl_d = scl_q; sdo_d = sdo_q;
    nack_d = nack_q; done_d = 1'b0;
    tmr_d = tick ? 16'h0 : tmr_q + 16'h1;
    case (st_q)
      GSITP_M_IDLE: begin
        scl_d = 1'b1; sdo_d = 1'b1; tmr_d = 16'h0;
        if (req_valid) begin
          rd_d = req_read; reg_d = req_reg; dat_d = req_data; ph_d = 3'h0;
          nack_d = 1'b0; st_d = GSITP_M_START;
        end
      end
      GSITP_M_START: if (tick) begin
        if (!sdo_q || !scl_q) begin
          if (!scl_q) scl_d = 1'b1;
          else begin
            scl_d = 1'b0; bit_d = 4'h0; sh_d = phase_byte(ph_q, reg_q, dat_q);
            st_d = GSITP_M_BITLO;
          end
        end else sdo_d = 1'b0;
      end
      GSITP_M_BITLO: if (tick) begin
        scl_d = 1'b1; st_d = GSITP_M_BITHI;
      end else if (tmr_q == 16'h1) begin
        // Released for the target's acknowledge; after the read byte it is the no-acknowledge.
        if (bit_q == GSITP_BIT_ACK)
          sdo_d = 1'b1;
        else
          sdo_d = (ph_q == 3'h4) ? 1'b1 : sh_q[7];
      end
      GSITP_M_BITHI: if (tick) begin
        scl_d = 1'b0; st_d = GSITP_M_BITLO; bit_d = bit_q + 4'h1;
        if (bit_q == GSITP_BIT_ACK) begin
          bit_d = 4'h0;
          if (ph_q == 3'h4 || (ph_q == 3'h2) || (ph_q == 3'h1 && rd_q)) begin
            st_d = (ph_q == 3'h1) ? GSITP_M_START : GSITP_M_STOPLO;
            ph_d = (ph_q == 3'h1) ? 3'h3 : ph_q;
            scl_d = (ph_q == 3'h1) ? 1'b0 : 1'b0;
          end else ph_d = (ph_q == 3'h3) ? 3'h4 : ph_q + 3'h1;
          sh_d = phase_byte(ph_d, reg_q, dat_q);
        end else sh_d = {sh_q[6:0], 1'b0};
      end else if (tmr_q == 16'h1) begin
        if (bit_q == GSITP_BIT_ACK && ph_q != 3'h4 && sda_sync_q[1]) begin
          nack_d = 1'b1; st_d = GSITP_M_STOPLO;
        end else if (ph_q == 3'h4 && bit_q < GSITP_BIT_ACK)
          rdat_d = {rdat_q[6:0], sda_sync_q[1]};
      end
      GSITP_M_STOPLO: if (tick) begin
        scl_d = 1'b0; sdo_d = 1'b0; st_d = GSITP_M_STOPHI;
      end
      GSITP_M_STOPHI: if (tick) begin
        if (!scl_q) scl_d = 1'b1;
        else begin
          sdo_d = 1'b1; st_d = GSITP_M_DONE;
        end
      end
      GSITP_M_DONE: if (tick) begin
        done_d = 1'b1; st_d = GSITP_M_IDLE;
      end
      default: st_d = GSITP_M_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sda_sync_q <= 2'h3; irq_sync_q <= 2'h3; st_q <= GSITP_M_IDLE; tmr_q <= 16'h0;
      bit_q <= 4'h0; ph_q <= 3'h0; sh_q <= 8'h00; rdat_q <= 8'h00; reg_q <= 8'h00;
      dat_q <= 8'h00; rd_q <= 1'b0; scl_q <= 1'b1; sdo_q <= 1'b1; nack_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      sda_sync_q <= {sda_sync_q[0], bus.sda_in}; irq_sync_q <= {irq_sync_q[0],
        bus.irq_request_n};
      st_q <= st_d; tmr_q <= tmr_d; bit_q <= bit_d; ph_q <= ph_d; sh_q <= sh_d;
      rdat_q <= rdat_d; reg_q <= reg_d; dat_q <= dat_d; rd_q <= rd_d; scl_q <= scl_d;
      sdo_q <= sdo_d; nack_q <= nack_d; done_q <= done_d;
    end
  end

  assign bus.scl_o         = 1'b0;
  assign bus.scl_oe        = !scl_q;
  assign bus.sda_m_o       = 1'b0;
  assign bus.sda_m_oe      = !sdo_q;
  assign bus.hw_shutdown_n = !shutdown_req;
  assign req_ready         = (st_q == GSITP_M_IDLE);
  assign done              = done_q;
  assign nack              = nack_q;
  assign rd_data           = rdat_q;
  assign irq_pending       = !irq_sync_q[1];

endmodule : gsitp_master
`default_nettype wire

// File: sim/gsitp_bus_asserts.sv
// Concurrent checks on the two-wire bus between the sensor target port and its master.
`timescale 1ns/10ps
`default_nettype none
module gsitp_bus_asserts
  import gsitp_pkg::*;
#(
  parameter int IRQ_HOLD_CYC = GSITP_IRQ_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_t_oe,
  input wire logic irq_request_n,
  input wire logic hw_shutdown_n
);
  // ****************
  // Bus decoder
  // ****************
  localparam int MIN_PERIOD = 2 * GSITP_SCL_HALF_CYC;
  logic        scl_q, sda_q, idle_q, idle_d, match_q, match_d, rd_q, rd_d, rise;
  logic [3:0]  bit_q, bit_d;
  logic [1:0]  byte_q, byte_d;
  logic [7:0]  sh_q, sh_d;
  logic [15:0] per_q, per_d;
  logic [31:0] lo_q, lo_d;
  assign rise = scl_in && !scl_q;
  // A level change of the data line with the clock high is a start or a stop, so it resets.
  always_comb begin
    {bit_d, byte_d, sh_d, idle_d, match_d, rd_d} = {bit_q, byte_q, sh_q, idle_q, match_q, rd_q};
    per_d = rise ? 16'h1 : per_q + {15'h0, per_q != 16'hffff};
    lo_d  = irq_request_n ? 32'h0 : lo_q + 32'h1;
    if (rise && bit_q == GSITP_BIT_ACK) begin
      bit_d  = 4'h0;
      byte_d = byte_q + {1'b0, byte_q != 2'h3};
    end else if (rise) begin
      sh_d  = {sh_q[6:0], sda_in};
      bit_d = bit_q + 4'h1;
      if (bit_q == GSITP_BIT_LAST && byte_q == 2'h0) begin
        match_d = sh_q[6:0] == GSITP_TARGET_ADDR;
        rd_d    = sda_in;
      end
    end
    if (scl_in && scl_q && sda_q != sda_in) begin
      idle_d = sda_in;
      bit_d  = 4'h0;
      byte_d = 2'h0;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {scl_q, sda_q, idle_q, match_q, rd_q} <= 5'h1c;
      {bit_q, byte_q, sh_q} <= 14'h0;
      per_q <= 16'hffff;
      lo_q  <= 32'h0;
    end else begin
      {scl_q, sda_q, idle_q, match_q, rd_q} <= {scl_in, sda_in, idle_d, match_d, rd_d};
      {bit_q, byte_q, sh_q} <= {bit_d, byte_d, sh_d};
      per_q <= per_d;
      lo_q  <= lo_d;
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_start;
    scl_q && scl_in && sda_q && !sda_in;
  endsequence
  sequence s_stop;
    scl_q && scl_in && !sda_q && sda_in;
  endsequence
  sequence s_ack;
    rise && bit_q == GSITP_BIT_ACK;
  endsequence
  chk_addr_ack: assert property (
    s_ack ##0 byte_q == 2'h0 |-> sda_in == !match_q) else $error("address ack wrong");
  chk_byte_ack: assert property (
    s_ack ##0 (byte_q != 2'h0 && match_q) |-> sda_in == rd_q) else $error("byte ack wrong");
  chk_bit_stable: assert property (
    scl_q && scl_in && bit_q >= 4'h2 && bit_q <= 4'h8 |-> sda_in == sda_q)
    else $error("data moved with clock high");
  chk_tgt_low_edge: assert property (
    $changed(sda_t_oe) |-> !scl_in) else $error("target drive changed with clock high");
  chk_idle_free: assert property (
    idle_q |-> scl_in && !sda_t_oe) else $error("bus not free while idle");
  chk_start_hold: assert property (
    s_start |=> scl_in [*8]) else $error("clock fell too soon after start");
  chk_stop_free: assert property (
    s_stop |=> (sda_in && scl_in) [*8]) else $error("bus busy right after stop");
  chk_scl_period: assert property (
    rise |-> per_q >= MIN_PERIOD) else $error("serial clock too fast");
  chk_irq_limit: assert property (
    lo_q <= 32'(IRQ_HOLD_CYC + 2)) else $error("interrupt held low too long");
  chk_sd_quiet: assert property (
    !hw_shutdown_n [*4] |-> !$fell(irq_request_n)) else $error("interrupt in shutdown");
endmodule // gsitp_bus_asserts
`default_nettype wire

// File: sim/tb_top.sv
// Bench: host master and target port on one bus, a second target probed by hand.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import gsitp_pkg::*;
;
  // Long enough that a status read releases the interrupt before the timeout does.
  localparam int HOLD = 25000;
  logic       clk_sys, resetn, motion_event, req_valid, req_read, shutdown_req;
  logic       req_ready, done, nack, irq_pending, shutdown, prox_mode, wr_strobe;
  logic [3:0] motion_flags;
  logic [2:0] emit_current;
  logic [7:0] req_reg, req_data, rd_data, wr_addr, wr_data, cap_addr, cap_data, d;
  logic [6:0] probe_tab [4] = '{7'h55, 7'h54, 7'h57, 7'h2a};
  int         fail_count, cmp_count, seed;
  gsitp_bus_if bus ();
  gsitp_bus_if bus_b ();
  gsitp_master u_gsitp_master (.clk_sys(clk_sys), .resetn(resetn), .bus(bus.master),
    .req_valid(req_valid), .req_read(req_read), .req_reg(req_reg), .req_data(req_data),
    .shutdown_req(shutdown_req), .req_ready(req_ready), .done(done), .nack(nack),
    .rd_data(rd_data), .irq_pending(irq_pending));
  gsitp_target #(.IRQ_HOLD_CYC(HOLD)) u_gsitp_target (.clk_sys(clk_sys), .resetn(resetn),
    .bus(bus.target), .motion_event(motion_event), .motion_flags(motion_flags),
    .shutdown(shutdown), .prox_mode(prox_mode), .emit_current(emit_current),
    .wr_data(wr_data), .wr_addr(wr_addr), .wr_strobe(wr_strobe));
  gsitp_target #(.IRQ_HOLD_CYC(HOLD)) u_gsitp_target_b (.clk_sys(clk_sys), .resetn(resetn),
    .bus(bus_b.target), .motion_event(motion_event), .motion_flags(motion_flags),
    .shutdown(), .prox_mode(), .emit_current(), .wr_data(), .wr_addr(), .wr_strobe());
  gsitp_bus_asserts #(.IRQ_HOLD_CYC(HOLD)) u_gsitp_bus_asserts (.clk_sys(clk_sys),
    .resetn(resetn), .scl_in(bus.scl_in), .sda_in(bus.sda_in), .sda_t_oe(bus.sda_t_oe),
    .irq_request_n(bus.irq_request_n), .hw_shutdown_n(bus.hw_shutdown_n));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (wr_strobe === 1'b1) begin
      cap_addr <= wr_addr;
      cap_data <= wr_data;
    end
  end
  function automatic logic [7:0] exp_status(input logic [3:0] f);
    return {4'h0, f};
  endfunction
  function automatic logic [7:0] exp_nack(input logic [6:0] a);
    return {7'h0, a != GSITP_TARGET_ADDR};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic rd, input logic [7:0] rg, input logic [7:0] dt);
    int n;
    check({7'h0, req_ready}, 8'h1);
    {req_valid, req_read, req_reg, req_data} = {1'b1, rd, rg, dt};
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 30000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 30000) begin
      fail_count++;
      wrap_up();
    end else begin
      check({7'h0, nack}, 8'h0);
    end
  endtask
  task automatic fire(input logic [3:0] f);
    {motion_flags, motion_event} = {f, 1'b1};
    @(negedge clk_sys);
    motion_event = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  // The probe clock runs at 64 ns and stands high between frames.
  task automatic bb_bit(input logic b, output logic s);
    #16 bus_b.sda_m_oe = !b;
    #16 bus_b.scl_oe = 1'b0;
    #16 s = bus_b.sda_in;
    #16 bus_b.scl_oe = 1'b1;
  endtask
  task automatic bb_byte(input logic [7:0] v, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) bb_bit(v[i], s);
    bb_bit(1'b1, ack_n);
  endtask
  task automatic bb_probe(input logic [6:0] a);
    logic k1, k2;
    bus_b.sda_m_oe = 1'b1;
    #32 bus_b.scl_oe = 1'b1;
    bb_byte({a, 1'b0}, k1);
    bb_byte({GSITP_TARGET_ADDR, 1'b0}, k2);
    #16 bus_b.sda_m_oe = 1'b1;
    #16 bus_b.scl_oe = 1'b0;
    #16 bus_b.sda_m_oe = 1'b0;
    #48;
    check({7'h0, k1}, exp_nack(a));
    check({7'h0, k2}, exp_nack(a));
  endtask
  initial begin
    {seed, fail_count, cmp_count} = {32'h4c4e, 64'h0};
    {resetn, req_valid, req_read, shutdown_req, motion_event} = 5'h0;
    {req_reg, req_data, motion_flags} = 20'h0;
    {bus_b.scl_o, bus_b.scl_oe, bus_b.sda_m_o, bus_b.sda_m_oe, bus_b.hw_shutdown_n} = 5'h1;
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys);
    check({7'h0, shutdown}, 8'h1);
    check({7'h0, bus.irq_request_n}, 8'h1);
    $display("Test reset values done");
    d = 8'($random(seed)) | 8'h01;
    xfer(1'b0, GSITP_REG_SHUTDN, d);
    check(cap_addr, GSITP_REG_SHUTDN);
    check(cap_data, d);
    check({7'h0, shutdown}, 8'h0);
    d = 8'($random(seed));
    xfer(1'b0, GSITP_REG_CONFIG, d);
    check(cap_addr, GSITP_REG_CONFIG);
    check({4'h0, emit_current, prox_mode}, {4'h0, d[3:0]});
    $display("Test register writes done");
    shutdown_req = 1'b1;
    repeat (8) @(negedge clk_sys);
    check({7'h0, shutdown}, 8'h1);
    fire(4'($random(seed)));
    check({7'h0, bus.irq_request_n}, 8'h1);
    shutdown_req = 1'b0;
    repeat (8) @(negedge clk_sys);
    check({7'h0, shutdown}, 8'h0);
    $display("Test shutdown pin done");
    fire(4'($random(seed)));
    check({7'h0, bus.irq_request_n}, 8'h0);
    repeat (HOLD - 20) @(negedge clk_sys);
    check({7'h0, bus.irq_request_n}, 8'h0);
    repeat (30) @(negedge clk_sys);
    check({7'h0, bus.irq_request_n}, 8'h1);
    $display("Test interrupt timeout done");
    d = 8'($random(seed));
    fire(d[3:0]);
    check({7'h0, bus.irq_request_n}, 8'h0);
    xfer(1'b1, GSITP_REG_STATUS, 8'h00);
    check(rd_data, exp_status(d[3:0]));
    check({6'h0, irq_pending, bus.irq_request_n}, 8'h1);
    $display("Test status read done");
    for (int i = 0; i < 8; i++) bb_probe(i < 4 ? probe_tab[i] : 7'($random(seed)));
    $display("Test address probes done");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
